/* File: core/ssf_params.svh */
// Shared constants of the subsector erase flash link
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

// Clock rate of both system clocks
`define SSF_CLK_MHZ 100

// Command codes
`define SSF_OP_WREN 8'h06
`define SSF_OP_WRDI 8'h04
`define SSF_OP_RDSR 8'h05
`define SSF_OP_WRITE 8'h02
`define SSF_OP_ERASE 8'h20

// Status byte fields
`define SSF_ST_WIP 0
`define SSF_ST_WEL 1

// Frame lengths in serial clocks
`define SSF_BITS_OP 8
`define SSF_BITS_ADDR 32
`define SSF_BITS_DATA 40
`define SSF_BITS_RDSR 16

// Array geometry
`define SSF_ADDR_W 24
`define SSF_MEM_ABITS 16
`define SSF_SUB_ABITS 12
`define SSF_ERASED 8'hff

// Timing figures
`define SSF_T_ESS_TYP_MS 30
`define SSF_T_ESS_MAX_MS 300
`define SSF_T_WB_TYP_US 400
`define SSF_T_WB_MAX_US 800
`define SSF_T_CSH_NS 100
`define SSF_F_SCLK_MAX_MHZ 100

// Derived cycle counts
`define SSF_ESS_CYCLES (`SSF_T_ESS_TYP_MS * `SSF_CLK_MHZ * 1000)
`define SSF_WB_CYCLES (`SSF_T_WB_TYP_US * `SSF_CLK_MHZ)
`define SSF_CSH_CYCLES ((`SSF_T_CSH_NS * `SSF_CLK_MHZ + 999) / 1000)
`define SSF_SCLK_HALF ((`SSF_CLK_MHZ + 2 * `SSF_F_SCLK_MAX_MHZ - 1) / (2 * `SSF_F_SCLK_MAX_MHZ) + 1)

`endif

/* File: core/ssf_pkg.sv */
// Types of the subsector erase flash link
package ssf_pkg;
	typedef enum logic [2:0] {
		OP_WREN = 3'h0,
		OP_WRDI = 3'h1,
		OP_RDSR = 3'h2,
		OP_ERASE = 3'h3,
		OP_WRITE = 3'h4
	} ssf_op_e;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_FRAME = 3'b010,
		HS_GAP = 3'b100
	} ssf_hstate_e;
endpackage : ssf_pkg

/* File: core/ssf_link_if.sv */
// Serial link between host controller and flash device
`timescale 1ns/10ps
`default_nettype none
interface ssf_link_if;
	logic chipSelectLow;
	logic serialClock;
	logic serialInputLine;
	logic serialOutputLine;
	logic serialOutputEn;

	modport dev (
		input chipSelectLow,
		input serialClock,
		input serialInputLine,
		output serialOutputLine,
		output serialOutputEn
	);

	modport host (
		output chipSelectLow,
		output serialClock,
		output serialInputLine,
		input serialOutputLine
	);
endinterface : ssf_link_if
`default_nettype wire

/* File: core/ssf_device.sv */
// Flash device end: command capture on the serial clock, self-timed cycles on the system clock
//
// Function
// - Subsector erase opcode 20h comes first.
// - Erase sets every subsector byte to ones.
// - Host sends write enable before erase.
// - Host sends 24-bit address after opcode.
// - Any address selects its whole subsector.
// - Host deselects only after eighth bit of last address byte.
// - Erase starts when chip select rises.
// - Busy flag reads one during erase.
// - Write enable latch cleared before cycle ends.
// - Host waits or polls before further programming.
// - Selected device is active.
// - Deselected device stays active until cycles end.
// - Write-class serial clock at most 100 MHz.
// - Input data sampled on rising serial clock.
// - Chip select high at least 100 ns.
// - Byte write lasts typically 0.4 ms.
// - Write enable opcode 06h sets latch.
// - Subsector erase lasts typically 30 ms.
`timescale 1ns/10ps
`default_nettype none
`include "ssf_params.svh"
module ssf_device #(
	parameter int MEM_ABITS = `SSF_MEM_ABITS,
	parameter int SUB_ABITS = `SSF_SUB_ABITS,
	parameter int ERASE_CYCLES = `SSF_ESS_CYCLES,
	parameter int WRITE_CYCLES = `SSF_WB_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	ssf_link_if.dev link,
	input wire logic [MEM_ABITS-1:0] memRdAddr,
	output logic [7:0] memRdData,
	output logic activeMode,
	output logic writeInProgress,
	output logic writeEnableLatch
);
	localparam logic [6:0] LAST_OP = 7'(`SSF_BITS_OP - 1);
	localparam logic [6:0] LAST_ADDR = 7'(`SSF_BITS_ADDR - 1);
	localparam logic [6:0] LAST_DATA = 7'(`SSF_BITS_DATA - 1);
	localparam logic [6:0] BITS_OP = 7'(`SSF_BITS_OP);
	localparam logic [6:0] BITS_ADDR = 7'(`SSF_BITS_ADDR);
	localparam logic [6:0] BITS_DATA = 7'(`SSF_BITS_DATA);
	localparam logic [6:0] COUNT_TOP = 7'h7f;

	// Link domain
	logic linkClear;
	logic [6:0] bitCount;
	logic [6:0] next_bitCount;
	logic [6:0] frameBits;
	logic [6:0] shiftIn;
	logic [7:0] nextShift;
	logic [7:0] opReg;
	logic [23:0] addrReg;
	logic [7:0] dataReg;
	logic frameTog;
	logic [1:0] statMeta;
	logic [1:0] statSync;
	logic [7:0] statusByte;
	logic dout;

	// System clock domain
	logic csMeta;
	logic csSync;
	logic csPrev;
	logic togMeta;
	logic togSync;
	logic togTaken;
	logic frameEnd;
	logic busy;
	logic wel;
	logic [31:0] timer;
	logic erasing;
	logic [MEM_ABITS-1:0] erasePtr;
	logic [MEM_ABITS-1:0] subBase;
	logic [MEM_ABITS-1:0] byteAddr;
	logic subLast;
	logic doWren;
	logic doWrdi;
	logic doErase;
	logic doWrite;
	logic [7:0] mem [2**MEM_ABITS];

	// Bit counter restarts whenever the device is deselected
	assign linkClear = rst | link.chipSelectLow;
	assign next_bitCount = (bitCount == COUNT_TOP) ? COUNT_TOP : bitCount + 7'h01;
	assign nextShift = {shiftIn, link.serialInputLine};

	always_ff @(posedge link.serialClock or posedge linkClear) begin
		if (linkClear) begin
			bitCount <= 7'h00;
		end else begin
			bitCount <= next_bitCount;
		end
	end

	// Capture on rising serial clock; fields stay put after deselect
	always_ff @(posedge link.serialClock or posedge rst) begin
		if (rst) begin
			shiftIn <= 7'h00;
			frameBits <= 7'h00;
			opReg <= 8'h00;
			addrReg <= 24'h000000;
			dataReg <= 8'h00;
			frameTog <= 1'b0;
		end else begin
			shiftIn <= nextShift[6:0];
			frameBits <= next_bitCount;
			if (bitCount == 7'h00) begin
				frameTog <= ~frameTog;
			end
			if (bitCount == LAST_OP) begin
				opReg <= nextShift;
			end
			if (bitCount > LAST_OP && bitCount <= LAST_ADDR) begin
				addrReg <= {addrReg[22:0], link.serialInputLine};
			end
			if (bitCount == LAST_DATA) begin
				dataReg <= nextShift;
			end
		end
	end

	// Status levels cross into the link domain
	always_ff @(posedge link.serialClock or posedge rst) begin
		if (rst) begin
			statMeta <= 2'h0;
			statSync <= 2'h0;
		end else begin
			statMeta <= {wel, busy};
			statSync <= statMeta;
		end
	end

	always_comb begin
		statusByte = 8'h00;
		statusByte[`SSF_ST_WIP] = statSync[0];
		statusByte[`SSF_ST_WEL] = statSync[1];
	end

	// Status byte leaves on falling serial clock, most significant bit first
	always_ff @(negedge link.serialClock or posedge rst) begin
		if (rst) begin
			dout <= 1'b0;
		end else begin
			dout <= statusByte[3'h7 - bitCount[2:0]];
		end
	end

	assign link.serialOutputLine = dout;
	assign link.serialOutputEn = ~link.chipSelectLow & (opReg == `SSF_OP_RDSR) & (bitCount >= BITS_OP);

	// Chip select and frame toggle cross into the system clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			csMeta <= 1'b1;
			csSync <= 1'b1;
			csPrev <= 1'b1;
			togMeta <= 1'b0;
			togSync <= 1'b0;
			togTaken <= 1'b0;
		end else if (ce) begin
			csMeta <= link.chipSelectLow;
			csSync <= csMeta;
			csPrev <= csSync;
			togMeta <= frameTog;
			togSync <= togMeta;
			if (frameEnd) begin
				togTaken <= togSync;
			end
		end
	end

	// Command decode at the end of a clocked frame
	assign frameEnd = csSync & ~csPrev & (togSync != togTaken);
	assign busy = (timer != 32'h0);
	assign doWren = frameEnd & ~busy & (opReg == `SSF_OP_WREN) & (frameBits == BITS_OP);
	assign doWrdi = frameEnd & ~busy & (opReg == `SSF_OP_WRDI) & (frameBits == BITS_OP);
	assign doErase = frameEnd & ~busy & wel & (opReg == `SSF_OP_ERASE) & (frameBits >= BITS_ADDR);
	assign doWrite = frameEnd & ~busy & wel & (opReg == `SSF_OP_WRITE) & (frameBits >= BITS_DATA);
	assign byteAddr = addrReg[MEM_ABITS-1:0];
	assign subBase = {byteAddr[MEM_ABITS-1:SUB_ABITS], {SUB_ABITS{1'b0}}};
	assign subLast = &erasePtr[SUB_ABITS-1:0];

	// Self-timed cycle timer and write enable latch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer <= 32'h0;
			wel <= 1'b0;
		end else if (ce) begin
			if (doErase) begin
				timer <= 32'(ERASE_CYCLES);
			end else if (doWrite) begin
				timer <= 32'(WRITE_CYCLES);
			end else if (busy) begin
				timer <= timer - 32'h1;
			end
			if (doWren) begin
				wel <= 1'b1;
			end else if (doWrdi | doErase | doWrite) begin
				wel <= 1'b0;
			end
		end
	end

	// Erase pointer walks the selected subsector once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			erasing <= 1'b0;
			erasePtr <= '0;
		end else if (ce) begin
			if (doErase) begin
				erasing <= 1'b1;
				erasePtr <= subBase;
			end else if (erasing) begin
				erasePtr <= erasePtr + {{(MEM_ABITS-1){1'b0}}, 1'b1};
				if (subLast) begin
					erasing <= 1'b0;
				end
			end
		end
	end

	// Array: erase fills ones, programming only clears bits
	always_ff @(posedge clk) begin
		if (ce) begin
			if (erasing) begin
				mem[erasePtr] <= `SSF_ERASED;
			end else if (doWrite) begin
				mem[byteAddr] <= mem[byteAddr] & dataReg;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			memRdData <= 8'h00;
		end else if (ce) begin
			memRdData <= mem[memRdAddr];
		end
	end

	assign activeMode = ~csSync | busy;
	assign writeInProgress = busy;
	assign writeEnableLatch = wel;
endmodule : ssf_device
`default_nettype wire

/* File: core/ssf_host.sv */
// Host controller end: frames commands, divides the serial clock, polls for completion
`timescale 1ns/10ps
`default_nettype none
`include "ssf_params.svh"
module ssf_host #(
	parameter int SCLK_HALF = `SSF_SCLK_HALF,
	parameter int GAP_CYCLES = `SSF_CSH_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	ssf_link_if.host link,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire ssf_pkg::ssf_op_e cmdOp,
	input wire logic [23:0] cmdAddr,
	input wire logic [7:0] cmdData,
	output logic rspValid,
	output logic [7:0] rspStatus
);
	function automatic logic [39:0] frame_word(input ssf_pkg::ssf_op_e op, input logic [23:0] a, input logic [7:0] d);
		unique case (op)
			ssf_pkg::OP_WREN: frame_word = {`SSF_OP_WREN, 32'h0};
			ssf_pkg::OP_WRDI: frame_word = {`SSF_OP_WRDI, 32'h0};
			ssf_pkg::OP_RDSR: frame_word = {`SSF_OP_RDSR, 32'h0};
			ssf_pkg::OP_ERASE: frame_word = {`SSF_OP_ERASE, a, 8'h00};
			ssf_pkg::OP_WRITE: frame_word = {`SSF_OP_WRITE, a, d};
			default: frame_word = {`SSF_OP_RDSR, 32'h0};
		endcase
	endfunction : frame_word

	function automatic logic [5:0] frame_bits(input ssf_pkg::ssf_op_e op);
		unique case (op)
			ssf_pkg::OP_RDSR: frame_bits = 6'(`SSF_BITS_RDSR);
			ssf_pkg::OP_ERASE: frame_bits = 6'(`SSF_BITS_ADDR);
			ssf_pkg::OP_WRITE: frame_bits = 6'(`SSF_BITS_DATA);
			default: frame_bits = 6'(`SSF_BITS_OP);
		endcase
	endfunction : frame_bits

	ssf_pkg::ssf_hstate_e state;
	ssf_pkg::ssf_op_e mainOp;
	ssf_pkg::ssf_op_e loadOp;
	logic [23:0] mainAddr;
	logic [7:0] mainData;
	logic [23:0] loadAddr;
	logic [7:0] loadData;
	logic cs;
	logic sclk;
	logic [7:0] divCnt;
	logic [5:0] bitsLeft;
	logic [39:0] shiftOut;
	logic [7:0] shiftIn;
	logic [7:0] gapCnt;
	logic pendMain;
	logic pollNext;
	logic lastRdsr;
	logic doutMeta;
	logic doutSync;
	logic isIdle;
	logic gapDone;
	logic wantPoll;
	logic loadNow;
	logic halfDone;
	logic needWren;

	assign isIdle = (state == ssf_pkg::HS_IDLE);
	assign needWren = (cmdOp == ssf_pkg::OP_ERASE) | (cmdOp == ssf_pkg::OP_WRITE);
	assign gapDone = (state == ssf_pkg::HS_GAP) & (gapCnt == 8'h00);
	assign wantPoll = pollNext & (~lastRdsr | shiftIn[`SSF_ST_WIP]);
	assign loadNow = (isIdle & cmdValid) | (gapDone & (pendMain | wantPoll));
	assign loadOp = isIdle ? (needWren ? ssf_pkg::OP_WREN : cmdOp) : (pendMain ? mainOp : ssf_pkg::OP_RDSR);
	assign loadAddr = isIdle ? cmdAddr : mainAddr;
	assign loadData = isIdle ? cmdData : mainData;
	assign halfDone = (divCnt == 8'(SCLK_HALF - 1));
	assign cmdReady = isIdle;

	assign link.chipSelectLow = cs;
	assign link.serialClock = sclk;
	assign link.serialInputLine = shiftOut[39];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			doutMeta <= 1'b0;
			doutSync <= 1'b0;
		end else if (ce) begin
			doutMeta <= link.serialOutputLine;
			doutSync <= doutMeta;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ssf_pkg::HS_IDLE;
			mainOp <= ssf_pkg::OP_WREN;
			mainAddr <= 24'h000000;
			mainData <= 8'h00;
			cs <= 1'b1;
			sclk <= 1'b0;
			divCnt <= 8'h00;
			bitsLeft <= 6'h00;
			shiftOut <= 40'h0;
			shiftIn <= 8'h00;
			gapCnt <= 8'h00;
			pendMain <= 1'b0;
			pollNext <= 1'b0;
			lastRdsr <= 1'b0;
			rspValid <= 1'b0;
			rspStatus <= 8'h00;
		end else if (ce) begin
			rspValid <= 1'b0;
			if (loadNow) begin
				state <= ssf_pkg::HS_FRAME;
				cs <= 1'b0;
				divCnt <= 8'h00;
				shiftOut <= frame_word(loadOp, loadAddr, loadData);
				bitsLeft <= frame_bits(loadOp);
				lastRdsr <= (loadOp == ssf_pkg::OP_RDSR);
				if (isIdle) begin
					mainOp <= cmdOp;
					mainAddr <= cmdAddr;
					mainData <= cmdData;
					pendMain <= needWren;
					pollNext <= 1'b0;
				end else if (pendMain) begin
					pendMain <= 1'b0;
					pollNext <= 1'b1;
				end
			end else if (state == ssf_pkg::HS_FRAME) begin
				if (halfDone) begin
					divCnt <= 8'h00;
					sclk <= ~sclk;
					if (sclk) begin
						shiftIn <= {shiftIn[6:0], doutSync};
						bitsLeft <= bitsLeft - 6'h01;
						shiftOut <= {shiftOut[38:0], 1'b0};
						if (bitsLeft == 6'h01) begin
							cs <= 1'b1;
							state <= ssf_pkg::HS_GAP;
							gapCnt <= 8'(GAP_CYCLES - 1);
						end
					end
				end else begin
					divCnt <= divCnt + 8'h01;
				end
			end else if (state == ssf_pkg::HS_GAP) begin
				if (gapCnt != 8'h00) begin
					gapCnt <= gapCnt - 8'h01;
				end else begin
					state <= ssf_pkg::HS_IDLE;
					rspValid <= 1'b1;
					rspStatus <= shiftIn;
					pollNext <= 1'b0;
				end
			end
		end
	end
endmodule : ssf_host
`default_nettype wire

/* File: verification/ssf_link_properties.sv */
// Concurrent checks on the serial link and device status
`timescale 1ns/10ps
`default_nettype none
module ssf_link_properties #(
	parameter int ERASE_CYCLES = 5000,
	parameter int WRITE_CYCLES = 50
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic chipSelectLow,
	input wire logic serialClock,
	input wire logic serialInputLine,
	input wire logic serialOutputEn,
	input wire logic activeMode,
	input wire logic writeInProgress,
	input wire logic writeEnableLatch
);
	int busyCount;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Length of the current busy stretch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busyCount <= 0;
		end else if (writeInProgress) begin
			busyCount <= busyCount + 1;
		end else begin
			busyCount <= 0;
		end
	end
	select_active_a: assert property ($fell(chipSelectLow) |-> ##[1:4] activeMode)
		else $error("activeMode missing after select");
	standby_idle_a: assert property (chipSelectLow [*6] ##0 !writeInProgress |-> !activeMode)
		else $error("activeMode while idle");
	busy_active_a: assert property (writeInProgress |-> activeMode)
		else $error("standby while busy");
	start_deselect_a: assert property ($rose(writeInProgress) |-> chipSelectLow && $past(chipSelectLow, 2))
		else $error("cycle started while selected");
	latch_clear_a: assert property ($fell(writeInProgress) |-> !writeEnableLatch)
		else $error("latch set at cycle end");
	busy_length_a: assert property ($fell(writeInProgress) |->
		(busyCount == ERASE_CYCLES || busyCount == WRITE_CYCLES))
		else $error("busy length wrong");
	clock_framed_a: assert property (chipSelectLow |-> !serialClock)
		else $error("serial clock outside frame");
	clock_rate_a: assert property ($rose(serialClock) |-> serialClock [*2])
		else $error("serial clock too fast");
	data_hold_a: assert property (serialClock |-> $stable(serialInputLine))
		else $error("data moved while clock high");
	select_gap_a: assert property ($rose(chipSelectLow) |-> chipSelectLow [*8] ##1 chipSelectLow [*2])
		else $error("select gap too short");
	drive_selected_a: assert property (serialOutputEn |-> !chipSelectLow)
		else $error("output driven while deselected");
	cover property ($rose(writeInProgress));
	cover property ($rose(writeEnableLatch));
	cover property (serialOutputEn);
endmodule : ssf_link_properties
`default_nettype wire

/* File: verification/tb_top.sv */
// Testbench joining host and device ends, with a second bench-driven device
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int EN = 5000;
	localparam int WN = 50;
	logic clk, rst, ce, cmdValid, cmdReady, rspValid;
	logic actA, wipA, welA, actB, wipB, welB;
	ssf_pkg::ssf_op_e cmdOp;
	logic [23:0] cmdAddr;
	logic [7:0] cmdData, rspStatus, rdA, rdB, lastByte;
	logic [15:0] memRdAddr;
	logic [31:0] shiftReg, eraseWord;
	int bitCnt, lastBits, wipCycles, n_mismatch, n_tests;
	ssf_link_if lnk();
	ssf_link_if lnk2();
	ssf_host u_ssf_host (.clk(clk), .rst(rst), .ce(ce), .link(lnk), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspStatus(rspStatus));
	ssf_device #(.ERASE_CYCLES(EN), .WRITE_CYCLES(WN)) u_ssf_device (.clk(clk), .rst(rst), .ce(ce), .link(lnk),
		.memRdAddr(memRdAddr), .memRdData(rdA), .activeMode(actA), .writeInProgress(wipA), .writeEnableLatch(welA));
	ssf_device #(.ERASE_CYCLES(EN), .WRITE_CYCLES(WN)) u_ssf_device_b (.clk(clk), .rst(rst), .ce(ce), .link(lnk2),
		.memRdAddr(memRdAddr), .memRdData(rdB), .activeMode(actB), .writeInProgress(wipB), .writeEnableLatch(welB));
	ssf_link_properties #(.ERASE_CYCLES(EN), .WRITE_CYCLES(WN)) u_ssf_link_properties (.clk(clk), .rst(rst),
		.chipSelectLow(lnk.chipSelectLow), .serialClock(lnk.serialClock), .serialInputLine(lnk.serialInputLine),
		.serialOutputEn(lnk.serialOutputEn), .activeMode(actA), .writeInProgress(wipA), .writeEnableLatch(welA));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Frame capture on the joined link
	always @(posedge lnk.serialClock) begin
		if (!lnk.chipSelectLow) begin
			shiftReg = {shiftReg[30:0], lnk.serialInputLine};
			bitCnt++;
		end
	end
	always @(posedge lnk.chipSelectLow) begin
		lastBits = bitCnt;
		lastByte = shiftReg[7:0];
		if (bitCnt == 32) eraseWord = shiftReg;
		bitCnt = 0;
	end
	always @(posedge clk) begin
		if (wipA === 1'b1) wipCycles++;
	end
	task automatic check_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte
	task automatic check_count(input string what, input int exp, input int got);
		n_tests++;
		if (got != exp) begin
			n_mismatch++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_count
	task automatic host_cmd(input ssf_pkg::ssf_op_e op, input logic [23:0] a, input logic [7:0] d);
		int i;
		@(negedge clk);
		cmdOp = op;
		cmdAddr = a;
		cmdData = d;
		cmdValid = 1'b1;
		for (i = 0; i < 100 && cmdReady !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		cmdValid = 1'b0;
		for (i = 0; i < 20000 && rspValid !== 1'b1; i++) @(negedge clk);
		check_bit("rspValid", 1'b1, rspValid);
	endtask : host_cmd
	task automatic mem_check(input logic [15:0] a, input logic [7:0] exp, input logic devB);
		@(negedge clk);
		memRdAddr = a;
		@(negedge clk);
		check_byte("memRdData", exp, devB ? rdB : rdA);
	endtask : mem_check
	// Bench-made link clock at 15 ns, running only inside the frame
	task automatic frame_b(input logic [31:0] v, input int n);
		int i;
		#3;
		lnk2.chipSelectLow = 1'b0;
		for (i = n - 1; i >= 0; i--) begin
			lnk2.serialInputLine = v[i];
			#7.5 lnk2.serialClock = 1'b1;
			#7.5 lnk2.serialClock = 1'b0;
		end
		lnk2.serialInputLine = ~lnk2.serialInputLine;
		#7.5 lnk2.chipSelectLow = 1'b1;
		repeat (12) @(negedge clk);
	endtask : frame_b
	task automatic stop_test();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	initial begin
		#500000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		int i;
		{rst, ce, cmdValid, cmdAddr, cmdData, memRdAddr} = {1'b1, 1'b1, 1'b0, 24'h0, 8'h0, 16'h0};
		cmdOp = ssf_pkg::OP_RDSR;
		{lnk2.chipSelectLow, lnk2.serialClock, lnk2.serialInputLine} = 3'b100;
		{n_mismatch, n_tests, wipCycles, bitCnt, shiftReg, eraseWord} = '0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		check_bit("writeInProgress", 1'b0, wipA);
		check_bit("activeMode", 1'b0, actA);
		host_cmd(ssf_pkg::OP_RDSR, 24'h0, 8'h0);
		check_byte("rspStatus", 8'h00, rspStatus);
		host_cmd(ssf_pkg::OP_WREN, 24'h0, 8'h0);
		check_byte("wrenCode", 8'h06, lastByte);
		check_count("wrenBits", 8, lastBits);
		check_bit("writeEnableLatch", 1'b1, welA);
		host_cmd(ssf_pkg::OP_RDSR, 24'h0, 8'h0);
		check_byte("rspStatus", 8'h02, rspStatus);
		host_cmd(ssf_pkg::OP_WRDI, 24'h0, 8'h0);
		check_bit("writeEnableLatch", 1'b0, welA);
		host_cmd(ssf_pkg::OP_WRITE, 24'h000fff, 8'h00);
		host_cmd(ssf_pkg::OP_WRITE, 24'h002000, 8'h00);
		wipCycles = 0;
		host_cmd(ssf_pkg::OP_ERASE, 24'h001abc, 8'h0);
		check_byte("eraseCode", 8'h20, eraseWord[31:24]);
		check_byte("eraseAddrHi", 8'h00, eraseWord[23:16]);
		check_byte("eraseAddrMid", 8'h1a, eraseWord[15:8]);
		check_byte("eraseAddrLo", 8'hbc, eraseWord[7:0]);
		check_count("eraseBusy", EN, wipCycles);
		check_bit("writeInProgress", 1'b0, wipA);
		check_bit("writeEnableLatch", 1'b0, welA);
		check_bit("activeMode", 1'b0, actA);
		mem_check(16'h1000, 8'hff, 1'b0);
		mem_check(16'h1abc, 8'hff, 1'b0);
		mem_check(16'h1fff, 8'hff, 1'b0);
		mem_check(16'h0fff, 8'h00, 1'b0);
		mem_check(16'h2000, 8'h00, 1'b0);
		wipCycles = 0;
		host_cmd(ssf_pkg::OP_WRITE, 24'h001abc, 8'h5a);
		check_count("writeBusy", WN, wipCycles);
		mem_check(16'h1abc, 8'h5a, 1'b0);
		mem_check(16'h1abd, 8'hff, 1'b0);
		frame_b({8'h20, 24'h000abc}, 32);
		check_bit("writeInProgress", 1'b0, wipB);
		check_bit("activeMode", 1'b0, actB);
		frame_b(32'h06, 8);
		check_bit("writeEnableLatch", 1'b1, welB);
		frame_b({8'h20, 24'h000abc}, 32);
		check_bit("writeInProgress", 1'b1, wipB);
		check_bit("writeEnableLatch", 1'b0, welB);
		check_bit("activeMode", 1'b1, actB);
		for (i = 0; i < 6000 && wipB !== 1'b0; i++) @(negedge clk);
		check_bit("writeInProgress", 1'b0, wipB);
		mem_check(16'h0000, 8'hff, 1'b1);
		mem_check(16'h0fff, 8'hff, 1'b1);
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
